// File: logic/dss_exec.sv
// execution unit for subtract-with-borrow-to-memory and the two decrement-skip instructions
// How it works
// RULE1: subtract memory and inverted carry from accumulator, result written to memory only.
// RULE2: memory decrement variant writes operand minus one back to the same location.
// RULE3: both decrement variants skip the next instruction exactly when the result is zero.
// RULE4: a taken skip discards the prefetched instruction and adds one dummy cycle.
// RULE5: a nonzero result continues with the prefetched instruction, no dummy cycle.
// RULE6: accumulator variant writes operand minus one to accumulator, memory left untouched.
// RULE7: subtract updates overflow, zero, half-carry and carry; decrements change no flag.
`timescale 1ns/1ns
`include "dss_params.svh"
module dss_exec (
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    nrst,
    // instruction request
    input  wire logic                    req_valid,
    input  wire dss_pkg::dss_req_t       req,
    output logic                         req_ready_q,
    // write-back
    output dss_pkg::dss_wb_t             wb_q,
    output logic                         flag_we_q,
    output dss_pkg::dss_flags_t          flags_q,
    // skip handling
    output logic                         discard_q,
    output logic                         dummy_q
);
    typedef struct packed {
        logic [`DSS_DATA_W-1:0] data;
        dss_pkg::dss_flags_t    flags;
    } dss_alu_t;

    // acc - mem - !c computed as acc + ~mem + c
    function automatic dss_alu_t dss_sbc(input logic [`DSS_DATA_W-1:0] a,
                                         input logic [`DSS_DATA_W-1:0] m,
                                         input logic                   c);
        logic [`DSS_DATA_W:0]       sum;
        logic [`DSS_NIB_HI+1:0]     lo;
        dss_alu_t                   r;
        sum = {1'b0, a} + {1'b0, ~m} + {{`DSS_DATA_W{1'b0}}, c};
        lo  = {1'b0, a[`DSS_NIB_HI:0]} + {1'b0, ~m[`DSS_NIB_HI:0]} + {{(`DSS_NIB_HI+1){1'b0}}, c};
        r.data     = sum[`DSS_DATA_W-1:0];
        r.flags.c  = sum[`DSS_DATA_W];
        r.flags.ac = lo[`DSS_NIB_HI+1];
        r.flags.z  = (sum[`DSS_DATA_W-1:0] == `DSS_ZERO_VAL);
        r.flags.ov = (a[`DSS_SIGN_BIT] != m[`DSS_SIGN_BIT]) &&
                     (sum[`DSS_SIGN_BIT] != a[`DSS_SIGN_BIT]);
        return r;
    endfunction

    // operand minus one
    function automatic logic [`DSS_DATA_W-1:0] dss_dec(input logic [`DSS_DATA_W-1:0] m);
        return m - `DSS_DEC_STEP;
    endfunction

    dss_pkg::dss_state_t      state_q;
    logic                     take;
    logic                     is_dec;
    logic [`DSS_DATA_W-1:0]   dec_val;
    logic                     skip;
    dss_alu_t                 sbc_val;

    // request acceptance and combinational results
    assign take    = req_valid && req_ready_q;
    assign is_dec  = (req.op == dss_pkg::DSS_DEC_SKIP_ZERO_MEM) || (req.op == dss_pkg::DSS_DEC_SKIP_ZERO_ACC);
    assign dec_val = dss_dec(req.mem_val);
    assign skip    = take && is_dec && (dec_val == `DSS_ZERO_VAL); // [RULE3]
    assign sbc_val = dss_sbc(req.acc_val, req.mem_val, req.carry);

    // cycle state: one dummy cycle after a taken skip
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q     <= dss_pkg::DSS_ST_EXEC;
            req_ready_q <= 1'b1;
            discard_q   <= 1'b0;
            dummy_q     <= 1'b0;
        end else begin
            case (state_q)
                dss_pkg::DSS_ST_EXEC: begin
                    if (skip) begin
                        state_q     <= dss_pkg::DSS_ST_DUMMY; // [RULE4]
                        req_ready_q <= 1'b0;
                        discard_q   <= 1'b1;
                        dummy_q     <= 1'b1;
                    end else begin
                        state_q     <= dss_pkg::DSS_ST_EXEC; // [RULE5]
                        req_ready_q <= 1'b1;
                        discard_q   <= 1'b0;
                        dummy_q     <= 1'b0;
                    end
                end
                dss_pkg::DSS_ST_DUMMY: begin
                    state_q     <= dss_pkg::DSS_ST_EXEC;
                    req_ready_q <= 1'b1;
                    discard_q   <= 1'b0;
                    dummy_q     <= 1'b0;
                end
                default: begin
                    state_q     <= dss_pkg::DSS_ST_EXEC;
                    req_ready_q <= 1'b1;
                    discard_q   <= 1'b0;
                    dummy_q     <= 1'b0;
                end
            endcase
        end
    end

    // write-back data and its destination strobes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wb_q.data   <= `DSS_DATA_RST;
            wb_q.mem_we <= 1'b0;
            wb_q.acc_we <= 1'b0;
        end else if (take) begin
            case (req.op)
                dss_pkg::DSS_SUB_BORROW_TO_MEM: begin
                    wb_q.data   <= sbc_val.data; // [RULE1]
                    wb_q.mem_we <= 1'b1;
                    wb_q.acc_we <= 1'b0;
                end
                dss_pkg::DSS_DEC_SKIP_ZERO_MEM: begin
                    wb_q.data   <= dec_val; // [RULE2]
                    wb_q.mem_we <= 1'b1;
                    wb_q.acc_we <= 1'b0;
                end
                dss_pkg::DSS_DEC_SKIP_ZERO_ACC: begin
                    wb_q.data   <= dec_val; // [RULE6]
                    wb_q.mem_we <= 1'b0;
                    wb_q.acc_we <= 1'b1;
                end
                default: begin
                    wb_q.mem_we <= 1'b0;
                    wb_q.acc_we <= 1'b0;
                end
            endcase
        end else begin
            wb_q.mem_we <= 1'b0;
            wb_q.acc_we <= 1'b0;
        end
    end

    // flag update, subtract only
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flags_q   <= `DSS_FLAG_RST;
            flag_we_q <= 1'b0;
        end else if (take && (req.op == dss_pkg::DSS_SUB_BORROW_TO_MEM)) begin
            flags_q   <= sbc_val.flags; // [RULE7]
            flag_we_q <= 1'b1;
        end else begin
            flag_we_q <= 1'b0; // [RULE7]
        end
    end

    // subtract result lands in memory with the borrow applied
    sbc_to_mem_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE1]
        (take && req.op == dss_pkg::DSS_SUB_BORROW_TO_MEM) |=>
        (wb_q.mem_we && !wb_q.acc_we &&
         wb_q.data == 8'(($past(req.acc_val) - $past(req.mem_val)) - {7'h00, !$past(req.carry)})))
        else $error("subtract result or destination wrong");

    // memory decrement writes operand minus one to memory
    dec_mem_wb_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE2]
        (take && req.op == dss_pkg::DSS_DEC_SKIP_ZERO_MEM) |=>
        (wb_q.mem_we && !wb_q.acc_we && wb_q.data == 8'($past(req.mem_val) - 8'h01)))
        else $error("memory decrement write-back wrong");

    // skip taken exactly on a zero decrement
    skip_on_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE3]
        take |=> (discard_q == ($past(is_dec) && $past(req.mem_val) == 8'h01)))
        else $error("skip decision does not match zero result");

    // taken skip holds off the next request for exactly one cycle
    dummy_cycle_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE4]
        skip |=> (dummy_q && !req_ready_q) ##1 (!dummy_q && req_ready_q && !discard_q))
        else $error("dummy cycle length wrong");

    // nonzero decrement leaves the next cycle open
    no_skip_open_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE5]
        (take && is_dec && !skip) |=> (req_ready_q && !dummy_q && !discard_q))
        else $error("nonzero decrement stalled");

    // accumulator decrement never writes memory
    dec_acc_wb_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE6]
        (take && req.op == dss_pkg::DSS_DEC_SKIP_ZERO_ACC) |=>
        (wb_q.acc_we && !wb_q.mem_we && wb_q.data == 8'($past(req.mem_val) - 8'h01)))
        else $error("accumulator decrement write-back wrong");

    // flags move only after a subtract, with zero tracking the result
    flag_update_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE7]
        flag_we_q |-> (wb_q.mem_we && $past(req.op) == dss_pkg::DSS_SUB_BORROW_TO_MEM &&
                       flags_q.z == (wb_q.data == 8'h00)))
        else $error("flag update not tied to subtract");

    // flags hold through decrements
    flag_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE7]
        (take && is_dec) |=> (!flag_we_q && $stable(flags_q)))
        else $error("decrement changed flags");

    // a refused or absent request leaves every strobe low in the next cycle
    idle_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE4]
        !take |=> (!wb_q.mem_we && !wb_q.acc_we && !flag_we_q &&
                   !discard_q && !dummy_q))
        else $error("strobe without a taken request");

    // discard and dummy travel together and close the request port
    skip_pair_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE4]
        discard_q |-> (dummy_q && !req_ready_q))
        else $error("discard without dummy cycle");

    // only the decrement variants may skip
    only_dec_skip_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE3]
        (take && !is_dec) |=> (!discard_q && !dummy_q && req_ready_q))
        else $error("skip after a non-decrement");

    // a taken skip always carries a zero result
    skip_zero_data_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE3]
        skip |=> (wb_q.data == `DSS_ZERO_VAL))
        else $error("skip with nonzero result");

    // accumulator variant skips on zero just like the memory variant
    acc_skip_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE6]
        (take && req.op == dss_pkg::DSS_DEC_SKIP_ZERO_ACC && dec_val == `DSS_ZERO_VAL) |=>
        (discard_q && dummy_q && wb_q.acc_we && !wb_q.mem_we))
        else $error("accumulator decrement skip wrong");

    // flags move only on a taken subtract
    flags_still_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE7]
        !(take && req.op == dss_pkg::DSS_SUB_BORROW_TO_MEM) |=> $stable(flags_q))
        else $error("flags changed without subtract");
endmodule

// File: logic/dss_params.svh
// constants for the subtract / decrement-skip execution block
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH
`define DSS_DATA_W    8
`define DSS_SIGN_BIT  7
`define DSS_NIB_HI    3
`define DSS_DEC_STEP  8'h01
`define DSS_ZERO_VAL  8'h00
`define DSS_DATA_RST  8'h00
`define DSS_FLAG_RST  4'h0
`endif

// File: logic/dss_pkg.sv
// types shared by the subtract / decrement-skip execution block
`include "dss_params.svh"
package dss_pkg;
    typedef enum logic [1:0] {
        DSS_SUB_BORROW_TO_MEM,
        DSS_DEC_SKIP_ZERO_MEM,
        DSS_DEC_SKIP_ZERO_ACC
    } dss_op_t;

    typedef enum logic {
        DSS_ST_EXEC,
        DSS_ST_DUMMY
    } dss_state_t;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } dss_flags_t;

    typedef struct packed {
        dss_op_t                 op;
        logic [`DSS_DATA_W-1:0]  acc_val;
        logic [`DSS_DATA_W-1:0]  mem_val;
        logic                    carry;
    } dss_req_t;

    typedef struct packed {
        logic [`DSS_DATA_W-1:0]  data;
        logic                    mem_we;
        logic                    acc_we;
    } dss_wb_t;
endpackage

// File: sim/decrement_skip_subtract_exec_test.sv
// self-checking testbench for the subtract / decrement-skip execution unit
`timescale 1ns/1ns
module decrement_skip_subtract_exec_test;
    // clock, reset and request
    logic                sys_clk = 1'b0;
    logic                nrst = 1'b0;
    logic                req_valid = 1'b0;
    dss_pkg::dss_req_t   req = '0;
    // design outputs
    logic                req_ready_q;
    dss_pkg::dss_wb_t    wb_q;
    logic                flag_we_q;
    dss_pkg::dss_flags_t flags_q;
    logic                discard_q;
    logic                dummy_q;
    // bookkeeping
    int                  miscompares = 0;
    int                  num_checks = 0;
    logic [3:0]          flags_exp = 4'h0;
    logic                prev_skip = 1'b0;

    // 20 ns clock
    always #10 sys_clk = ~sys_clk;

    dss_exec u_dut (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid), .req(req), .req_ready_q(req_ready_q),
        .wb_q(wb_q), .flag_we_q(flag_we_q), .flags_q(flags_q), .discard_q(discard_q), .dummy_q(dummy_q));

    // compare one value and count it
    task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // counts and verdict, ends the run
    task automatic results;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // expected {ov,z,ac,c,result} of acc minus mem minus inverted carry
    function automatic logic [11:0] sub_exp(input logic [7:0] a, input logic [7:0] m, input logic c);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, ~m} + {8'h00, c};
        h = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, c};
        return {(a[7] != m[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
    endfunction

    // present one request, wait until taken, check the answer one cycle later
    task automatic run_op(input logic [1:0] op, input logic [7:0] a, input logic [7:0] m, input logic c,
                          input logic keep);
        logic [11:0] sx;
        logic        is_dec;
        logic        skip;
        int          n;
        sx = sub_exp(a, m, c);
        is_dec = (op == 2'd1) || (op == 2'd2);
        skip = is_dec && (m == 8'h01);
        req_valid = 1'b1;
        req = '{op: dss_pkg::dss_op_t'(op), acc_val: a, mem_val: m, carry: c};
        n = 0;
        while (req_ready_q !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            n++;
            chk({wb_q.mem_we, wb_q.acc_we, flag_we_q}, 20'h0, "strobe while refused");
            if (n > 3) begin
                miscompares++;
                results();
            end
        end
        chk(20'(n), {19'h0, prev_skip}, "dummy length");
        @(posedge sys_clk);
        #1;
        if (!keep) req_valid = 1'b0;
        if (op == 2'd0) flags_exp = sx[11:8];
        if (op == 2'd0) chk(wb_q.data, sx[7:0], "subtract result");
        if (is_dec) chk(wb_q.data, 8'(m - 8'h01), "decrement result");
        chk({wb_q.mem_we, wb_q.acc_we}, {op == 2'd0 || op == 2'd1, op == 2'd2}, "write target");
        chk({flag_we_q, flags_q}, {op == 2'd0, flags_exp}, "flags");
        chk({discard_q, dummy_q, req_ready_q}, {skip, skip, !skip}, "skip");
        prev_skip = keep & skip;
    endtask

    // main sequence
    initial begin
        void'($urandom(32'hcb7a));
        repeat (6) @(posedge sys_clk);
        #1;
        chk({req_ready_q, wb_q, flag_we_q, flags_q, discard_q, dummy_q}, 20'h20000, "reset values");
        nrst = 1'b1;
        $display("test reset done");
        run_op(2'd1, 8'h00, 8'h01, 1'b0, 1'b1);
        run_op(2'd2, 8'h00, 8'h01, 1'b0, 1'b1);
        run_op(2'd1, 8'h00, 8'h00, 1'b0, 1'b1);
        run_op(2'd2, 8'h00, 8'h02, 1'b0, 1'b1);
        run_op(2'd0, 8'h00, 8'h00, 1'b0, 1'b1);
        run_op(2'd0, 8'h80, 8'h01, 1'b1, 1'b1);
        run_op(2'd0, 8'h10, 8'h10, 1'b1, 1'b1);
        run_op(2'd1, 8'h00, 8'h01, 1'b0, 1'b1);
        run_op(2'd3, 8'h55, 8'h01, 1'b0, 1'b0);
        $display("test corners done");
        @(posedge sys_clk);
        #1;
        for (int i = 0; i < 400; i++) begin
            run_op(2'($urandom % 3), 8'($urandom), ($urandom % 4 == 0) ? 8'h01 : 8'($urandom), 1'($urandom),
                   i != 399);
        end
        $display("test random done");
        results();
    end
endmodule
